/* File: core/vic_ctrl.sv */
`timescale 1ns/1ps
module vic_ctrl #(
  parameter bit HAS_TWOWIRE = 1'b1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Register access.
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_bit_en,
  output logic [7:0] reg_rdata,
  // Watchdog configuration.
  input wire logic [1:0] watchdog_mode,
  // Request pulses from sources.
  input wire logic watchdog_overflow_request,
  input wire logic [3:0] pin_edge_request,
  input wire logic serial_receive_done_request,
  input wire logic three_wire_transfer_done_request,
  input wire logic serial_transmit_done_request,
  input wire logic watch_timer_request,
  input wire logic interval_timer_request,
  input wire logic timer8_a_match_request,
  input wire logic timer8_b_match_request,
  input wire logic timer8_c_match_request,
  input wire logic timer16_match_request,
  input wire logic twowire_bus_request,
  input wire logic twowire_timeout_request,
  input wire logic conversion_done_request,
  // CPU core.
  input wire logic global_irq_enable,
  input wire logic cpu_busy,
  output logic irq_take,
  output logic [15:0] irq_vector,
  output logic irq_is_nmi,
  output logic clear_global_enable,
  output logic standby_release
);
  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] mask;
    logic nmi_pend;
    logic [4:0] wait_cnt;
    logic [7:0] rdata;
    logic take;
    logic [15:0] vector;
    logic is_nmi;
    logic clr_ie;
    logic release_stb;
  } vic_state_s;

  vic_state_s st_reg;
  vic_state_s st_next;

  function automatic logic [15:0] prio_vector(input logic [3:0] p);
    if (p == 4'h0) begin
      prio_vector = vic_pkg::VEC_WDT_MASKABLE;
    end else if (p < 4'(vic_pkg::SERIAL_RX_PRIO)) begin
      prio_vector = vic_pkg::VEC_PIN_BASE + 16'({p - 4'h1, 1'b0});
    end else begin
      prio_vector = vic_pkg::VEC_FIRST_INTERNAL
        + 16'({p - 4'(vic_pkg::SERIAL_RX_PRIO), 1'b0});
    end
  endfunction

  logic [15:0] src;
  logic [15:0] eligible;
  logic [3:0] win;
  logic any_elig;
  logic wdt_interval;
  logic wr_flag_lo, wr_flag_hi, wr_mask_lo, wr_mask_hi;
  logic [15:0] wr_bits, wr_val;

  assign wdt_interval = (watchdog_mode == vic_pkg::WDT_MODE_INTERVAL);

  always_comb begin
    src = {conversion_done_request,
           twowire_timeout_request & HAS_TWOWIRE,
           twowire_bus_request & HAS_TWOWIRE,
           timer16_match_request, timer8_c_match_request,
           timer8_b_match_request, timer8_a_match_request,
           interval_timer_request, watch_timer_request,
           serial_transmit_done_request,
           serial_receive_done_request | three_wire_transfer_done_request,
           pin_edge_request,
           watchdog_overflow_request & wdt_interval};
  end

  always_comb begin
    eligible = st_reg.flags & ~st_reg.mask;
    any_elig = |eligible;
    win = 4'h0;
    for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        win = 4'(i);
      end
    end
  end

  always_comb begin
    wr_flag_lo = reg_wr && reg_addr == vic_pkg::ADDR_FLAGS_LOW;
    wr_flag_hi = reg_wr && reg_addr == vic_pkg::ADDR_FLAGS_HIGH;
    wr_mask_lo = reg_wr && reg_addr == vic_pkg::ADDR_MASK_LOW;
    wr_mask_hi = reg_wr && reg_addr == vic_pkg::ADDR_MASK_HIGH;
    wr_bits = {wr_flag_hi ? reg_bit_en : 8'h00, wr_flag_lo ? reg_bit_en : 8'h00};
    wr_bits[0] = wr_bits[0] & wdt_interval;
    wr_bits[8] = wr_bits[8] | (wr_flag_lo & reg_bit_en[vic_pkg::WATCH_FLAG_BIT]);
    wr_val = {reg_wdata, reg_wdata};
    wr_val[8] = wr_flag_lo ? reg_wdata[vic_pkg::WATCH_FLAG_BIT] : reg_wdata[0];
  end

  always_comb begin
    st_next = st_reg;
    st_next.take = 1'b0;
    st_next.clr_ie = 1'b0;
    st_next.release_stb = |src | (watchdog_overflow_request & ~wdt_interval);
    // Software writes first, so a hardware request in the same cycle wins.
    st_next.flags = (st_reg.flags & ~wr_bits) | (wr_val & wr_bits);
    if (wr_mask_lo) begin
      st_next.mask[7:0] = (st_reg.mask[7:0] & ~reg_bit_en) | (reg_wdata & reg_bit_en);
    end
    if (wr_mask_hi) begin
      st_next.mask[15:8] = (st_reg.mask[15:8] & ~reg_bit_en) | (reg_wdata & reg_bit_en);
    end
    if (st_reg.nmi_pend && !cpu_busy) begin
      st_next.nmi_pend = 1'b0;
      st_next.take = 1'b1;
      st_next.is_nmi = 1'b1;
      st_next.vector = vic_pkg::VEC_NMI;
      st_next.clr_ie = 1'b1;
      st_next.wait_cnt = 5'h00;
    end else if (any_elig && global_irq_enable && !cpu_busy) begin
      if (st_reg.wait_cnt == vic_pkg::ACCEPT_DELAY - 5'h01) begin
        st_next.take = 1'b1;
        st_next.is_nmi = 1'b0;
        st_next.vector = prio_vector(win);
        st_next.clr_ie = 1'b1;
        st_next.flags[win] = 1'b0;
        st_next.wait_cnt = 5'h00;
      end else begin
        st_next.wait_cnt = st_reg.wait_cnt + 5'h01;
      end
    end else if (!any_elig) begin
      st_next.wait_cnt = 5'h00;
    end
    // Set after the take, so an overflow in the take cycle is not lost.
    if (watchdog_overflow_request && watchdog_mode == vic_pkg::WDT_MODE_1) begin
      st_next.nmi_pend = 1'b1;
    end
    st_next.flags = st_next.flags | src;
    if (!HAS_TWOWIRE) begin
      st_next.flags[14:13] = 2'b00;
    end
    unique case (reg_addr)
      vic_pkg::ADDR_FLAGS_LOW: st_next.rdata = {st_reg.flags[7:1],
                                   st_reg.flags[0] & wdt_interval};
      vic_pkg::ADDR_FLAGS_HIGH: st_next.rdata = st_reg.flags[15:8];
      vic_pkg::ADDR_MASK_LOW: st_next.rdata = st_reg.mask[7:0];
      vic_pkg::ADDR_MASK_HIGH: st_next.rdata = st_reg.mask[15:8];
      default: st_next.rdata = 8'h00;
    endcase
    if (!reg_rd) begin
      st_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{flags: {vic_pkg::FLAGS_RESET, vic_pkg::FLAGS_RESET},
                  mask: {vic_pkg::MASK_RESET, vic_pkg::MASK_RESET},
                  nmi_pend: 1'b0, wait_cnt: 5'h00, rdata: 8'h00, take: 1'b0,
                  vector: 16'h0000, is_nmi: 1'b0, clr_ie: 1'b0,
                  release_stb: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign irq_take = st_reg.take;
  assign irq_vector = st_reg.vector;
  assign irq_is_nmi = st_reg.is_nmi;
  assign clear_global_enable = st_reg.clr_ie;
  assign standby_release = st_reg.release_stb;

  AST_NMI_WINS: assert property (@(posedge clock) disable iff (!rstn)
    (st_reg.nmi_pend && !cpu_busy) |=> (irq_take && irq_is_nmi && irq_vector == 16'h0004))
    else $error("pending watchdog request not taken");
  AST_NMI_SET: assert property (@(posedge clock) disable iff (!rstn)
    (watchdog_overflow_request && watchdog_mode == 2'h1) |=> st_reg.nmi_pend)
    else $error("mode 1 overflow did not pend");
  AST_RELEASE: assert property (@(posedge clock) disable iff (!rstn)
    (|pin_edge_request) |=> standby_release)
    else $error("no standby release on request");
  AST_LOW_WINS: assert property (@(posedge clock) disable iff (!rstn)
    (irq_take && !irq_is_nmi) |-> !$past(eligible[0]) || irq_vector == 16'h0004)
    else $error("priority 0 lost arbitration");
  AST_VEC_RANGE: assert property (@(posedge clock) disable iff (!rstn)
    (irq_take && !irq_is_nmi) |-> irq_vector <= 16'h0022 && !irq_vector[0])
    else $error("vector out of range");
  AST_MASK_RESET: assert property (@(posedge clock) disable iff (!rstn)
    $rose(rstn) |-> st_reg.mask == 16'hFFFF)
    else $error("masks not set after reset");
  AST_ACCEPT_GATE: assert property (@(posedge clock) disable iff (!rstn)
    (irq_take && !irq_is_nmi) |-> $past(global_irq_enable) && $past(any_elig))
    else $error("accept without enable");
  AST_CLR_IE: assert property (@(posedge clock) disable iff (!rstn)
    irq_take |-> clear_global_enable)
    else $error("enable not cleared on accept");
  AST_LATENCY: assert property (@(posedge clock) disable iff (!rstn)
    (irq_take && !irq_is_nmi) |-> $past(st_reg.wait_cnt) == 5'h08)
    else $error("accept latency wrong");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (!rstn)
    src[3] |=> st_reg.flags[3])
    else $error("request lost against clear");
  AST_WDT_HIDDEN: assert property (@(posedge clock) disable iff (!rstn)
    (reg_rd && reg_addr == 16'hFFE0 && watchdog_mode != 2'h0) |=> !reg_rdata[0])
    else $error("watchdog flag visible outside interval mode");
  AST_BUSY_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    cpu_busy |=> !irq_take)
    else $error("request taken while core busy");
endmodule // vic_ctrl

/* File: shared/vic_pkg.sv */
package vic_pkg;
  localparam logic [15:0] ADDR_FLAGS_LOW = 16'hFFE0;
  localparam logic [15:0] ADDR_FLAGS_HIGH = 16'hFFE1;
  localparam logic [15:0] ADDR_MASK_LOW = 16'hFFE4;
  localparam logic [15:0] ADDR_MASK_HIGH = 16'hFFE5;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_FIRST_INTERNAL = 16'h000E;
  localparam logic [15:0] VEC_WDT_MASKABLE = 16'h0004;
  localparam logic [15:0] VEC_PIN_BASE = 16'h0006;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  localparam int unsigned SERIAL_RX_PRIO = 5;
  localparam int unsigned WATCH_FLAG_BIT = 7;
  localparam int unsigned NUM_SRC = 16;
  localparam int unsigned LAT_MIN = 9;
  localparam int unsigned LAT_MAX = 19;
  // Clocks from flag set to the vector strobe; lies inside LAT_MIN..LAT_MAX.
  localparam logic [4:0] ACCEPT_DELAY = 5'h09;
  localparam logic [1:0] WDT_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] WDT_MODE_1 = 2'h1;
endpackage

/* File: sim/vic_cpu_model.sv */
`timescale 1ns/1ps
module vic_cpu_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Controller side.
  input wire logic clear_global_enable,
  input wire logic enable_cmd,
  output logic global_irq_enable
);
  // Acceptance wins over a same-cycle enable, as in a real core.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      global_irq_enable <= 1'b0;
    end else if (clear_global_enable) begin
      global_irq_enable <= 1'b0;
    end else if (enable_cmd) begin
      global_irq_enable <= 1'b1;
    end
  end
endmodule // vic_cpu_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clock, rstn, reg_wr, reg_rd, three_wire, cpu_busy, enable_cmd;
  logic irq_take, irq_is_nmi, clear_global_enable, standby_release, global_irq_enable;
  logic [15:0] reg_addr, irq_vector, req, set;
  logic [7:0] reg_wdata, reg_bit_en, reg_rdata;
  logic [1:0] watchdog_mode;
  logic [31:0] lfsr;
  int mismatches, check_count, cycles, n, p;
  vic_ctrl i_vic_ctrl (.clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_bit_en,
    .reg_rdata, .watchdog_mode, .watchdog_overflow_request(req[0]),
    .pin_edge_request(req[4:1]), .serial_receive_done_request(req[5]),
    .three_wire_transfer_done_request(three_wire), .serial_transmit_done_request(req[6]),
    .watch_timer_request(req[7]), .interval_timer_request(req[8]),
    .timer8_a_match_request(req[9]), .timer8_b_match_request(req[10]),
    .timer8_c_match_request(req[11]), .timer16_match_request(req[12]),
    .twowire_bus_request(req[13]), .twowire_timeout_request(req[14]),
    .conversion_done_request(req[15]), .global_irq_enable, .cpu_busy, .irq_take,
    .irq_vector, .irq_is_nmi, .clear_global_enable, .standby_release);
  vic_cpu_model i_vic_cpu_model (.clock, .rstn, .clear_global_enable, .enable_cmd,
    .global_irq_enable);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic rw(input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clock) #1 reg_addr = a;
    reg_wdata = d;
    reg_bit_en = e;
    reg_wr = 1'b1;
    @(posedge clock) #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock) #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock) #1 reg_rd = 1'b0;
    check("rdata", {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic pulse(input logic [15:0] s);
    @(posedge clock) #1 req = s;
    @(posedge clock) #1 req = 16'h0000;
    check("standby", {15'h0000, standby_release}, 16'h0001);
  endtask
  task automatic ei();
    @(posedge clock) #1 enable_cmd = 1'b1;
    @(posedge clock) #1 enable_cmd = 1'b0;
  endtask
  task automatic wait_take(output int k);
    k = 0;
    while (irq_take !== 1'b1 && k < 40) begin
      @(posedge clock) #1 k++;
    end
  endtask
  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [15:0] vec(input int q);
    if (q == 0) return 16'h0004;
    if (q < 5) return 16'(6 + 2 * (q - 1));
    return 16'(14 + 2 * (q - 5));
  endfunction
  initial begin
    {rstn, reg_wr, reg_rd, three_wire, cpu_busy, enable_cmd} = 6'h00;
    {reg_addr, reg_wdata, req, watchdog_mode} = 42'h0;
    reg_bit_en = 8'hFF;
    lfsr = 32'h448F;
    repeat (2) @(posedge clock);
    #1 rstn = 1'b1;
    rd(16'hFFE0, 8'h00);
    rd(16'hFFE1, 8'h00);
    rd(16'hFFE4, 8'hFF);
    rd(16'hFFE5, 8'hFF);
    $display("reset values done");
    ei();
    pulse(16'h0002);
    pulse(16'h0002);
    wait_take(n);
    check("masked take", {15'h0000, irq_take}, 16'h0000);
    rd(16'hFFE0, 8'h02);
    rw(16'hFFE0, 8'h00, 8'hFF);
    rd(16'hFFE0, 8'h00);
    rw(16'hFFE4, 8'h00, 8'h02);
    rd(16'hFFE4, 8'hFD);
    pulse(16'h0002);
    wait_take(n);
    check("latency ok", 16'(n >= 9 && n <= 19), 16'h0001);
    check("pin vector", irq_vector, 16'h0006);
    $display("mask and latency done");
    rw(16'hFFE4, 8'h00, 8'hFF);
    rw(16'hFFE5, 8'h00, 8'hFF);
    repeat (8) begin
      lfsr = lfsr_step(lfsr);
      set = lfsr[15:0] & 16'hFE7F;
      ei();
      if (set != 16'h0000) pulse(set);
      while (set != 16'h0000) begin
        wait_take(n);
        for (p = 0; !set[p]; p++) ;
        check("vector", irq_vector, vec(p));
        check("clear enable", {15'h0000, clear_global_enable}, 16'h0001);
        check("maskable", {15'h0000, irq_is_nmi}, 16'h0000);
        set[p] = 1'b0;
        ei();
      end
    end
    $display("priority done");
    // A busy core must leave the shared serial flag pending until it is free.
    cpu_busy = 1'b1;
    @(posedge clock) #1 three_wire = 1'b1;
    @(posedge clock) #1 three_wire = 1'b0;
    check("standby shared", {15'h0000, standby_release}, 16'h0001);
    repeat (20) @(posedge clock);
    rd(16'hFFE0, 8'h20);
    cpu_busy = 1'b0;
    wait_take(n);
    check("shared vector", irq_vector, 16'h000E);
    check("busy latency", 16'(n >= 9 && n <= 19), 16'h0001);
    rw(16'hFFE1, 8'h00, 8'hFF);
    rd(16'hFFE1, 8'h00);
    $display("busy and shared source done");
    watchdog_mode = 2'h1;
    rw(16'hFFE0, 8'h01, 8'h01);
    rd(16'hFFE0, 8'h00);
    rw(16'hFFE4, 8'hFF, 8'hFF);
    pulse(16'h0001);
    wait_take(n);
    check("nmi vector", irq_vector, 16'h0004);
    check("nmi flag", {15'h0000, irq_is_nmi}, 16'h0001);
    check("nmi fast", 16'(n <= 2), 16'h0001);
    $display("nmi done");
    end_of_test();
  end
endmodule // testbench
